// File: core/fcd_pkg.sv
// fcd_pkg: constants and carriers for the parallel flash host controller
// assumes a byte-wide flash with 20 address bits behind asynchronous pins
package fcd_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 8;
   localparam int CLK_MHZ = 25;
   // bus phase times in ns; setup and strobe widths are least times
   localparam int T_SETUP_NS = 40;
   localparam int T_STROBE_NS = 80;
   localparam int T_HOLD_NS = 40;
   localparam int T_SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int T_STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int T_HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
   // pin register plus two sync flops delay the read data; the strobe
   // is stretched by this many cycles so the sample sees settled lines
   localparam int SYNC_LAG_CYC = 2;
   localparam int CNT_W = 4;
   // command data bytes
   localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
   localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
   localparam logic [7:0] CMD_AUTOSEL = 8'h90;
   localparam logic [7:0] CMD_PROGRAM = 8'hA0;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_RESUME = 8'h30;
   localparam logic [7:0] CMD_RESET = 8'hF0;
   // unlock addresses
   localparam logic [ADDR_W-1:0] ADDR_UNLOCK1 = 20'h00AAA;
   localparam logic [ADDR_W-1:0] ADDR_UNLOCK2 = 20'h00555;
   // identifier locations: bit one and bit zero select the code
   localparam logic [ADDR_W-1:0] ID_MANUF_LOC = 20'h00000;
   localparam logic [ADDR_W-1:0] ID_DEVICE_LOC = 20'h00001;
   localparam logic [ADDR_W-1:0] ID_PROTECT_LOC = 20'h00002;
   localparam int SECT_LSB = 13;
   localparam int SECT_W = 7;
   localparam int A6_BIT = 6;
   localparam logic [7:0] PROT_YES = 8'h01;
   localparam logic [7:0] PROT_NO = 8'h00;

   // user operations
   typedef enum logic [3:0] {
      FCD_OP_READ,
      FCD_OP_RESET,
      FCD_OP_ID_READ,
      FCD_OP_PROT_VERIFY,
      FCD_OP_PROGRAM,
      FCD_OP_CHIP_ERASE,
      FCD_OP_SECTOR_ERASE,
      FCD_OP_SUSPEND,
      FCD_OP_RESUME,
      FCD_OP_HV_ID_READ,
      FCD_OP_HV_PROTECT
   } fcd_op_t;

   typedef struct packed {
      fcd_op_t op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic unprotect;
   } fcd_req_t;

   // one bus cycle handed to the cycle engine
   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } fcd_cyc_t;

   // pin bundle driven toward the flash
   typedef struct packed {
      logic chip_select_n;
      logic output_gate_n;
      logic write_strobe_n;
      logic reset_n;
      logic id_hv_a9;
      logic id_hv_reset;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data_out;
      logic data_oe;
   } fcd_pins_t;
endpackage : fcd_pkg

// File: core/fcd_bus_cycle.sv
// fcd_bus_cycle: one read or write cycle on the flash pins
// assumes rd_data is already synchronised by the caller
`timescale 1ns/100ps
module fcd_bus_cycle (
   input wire logic core_clk, // system clock
   input wire logic rst, // async reset, active high
   input wire logic start, // one-cycle start pulse
   input wire fcd_pkg::fcd_cyc_t cyc, // cycle to run
   input wire logic [fcd_pkg::DATA_W-1:0] rd_data, // synced data lines
   output logic busy, // cycle running
   output logic done, // one-cycle end pulse
   output logic [fcd_pkg::DATA_W-1:0] rd_byte, // captured read data
   output logic cs_n, // chip select toward pins
   output logic oe_n, // output gate toward pins
   output logic we_n, // write strobe toward pins
   output logic [fcd_pkg::ADDR_W-1:0] addr, // address toward pins
   output logic [fcd_pkg::DATA_W-1:0] wdata, // write data
   output logic wdata_oe // write data drive enable
);
   typedef enum logic [1:0] {FCD_B_IDLE, FCD_B_SETUP, FCD_B_STROBE,
      FCD_B_HOLD} fcd_bst_t;
   fcd_bst_t st_r, st_nxt;
   logic [fcd_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   fcd_pkg::fcd_cyc_t cyc_r, cyc_nxt;
   logic [fcd_pkg::DATA_W-1:0] rb_r, rb_nxt;
   logic done_r, done_nxt;

   // phase sequencer; address is set before the strobe falls
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      cyc_nxt = cyc_r;
      rb_nxt = rb_r;
      done_nxt = 1'b0;
      unique case (st_r)
         FCD_B_IDLE: if (start) begin
            cyc_nxt = cyc;
            st_nxt = FCD_B_SETUP;
            cnt_nxt = fcd_pkg::CNT_W'(fcd_pkg::T_SETUP_CYC - 1);
         end
         FCD_B_SETUP: if (cnt_r == '0) begin
            st_nxt = FCD_B_STROBE;
            cnt_nxt = fcd_pkg::CNT_W'(fcd_pkg::T_STROBE_CYC +
               fcd_pkg::SYNC_LAG_CYC - 1);
         end else cnt_nxt = cnt_r - 1'b1;
         FCD_B_STROBE: if (cnt_r == '0) begin
            // sync lag is covered by the long strobe; sample at its end
            if (!cyc_r.write) rb_nxt = rd_data;
            st_nxt = FCD_B_HOLD;
            cnt_nxt = fcd_pkg::CNT_W'(fcd_pkg::T_HOLD_CYC - 1);
         end else cnt_nxt = cnt_r - 1'b1;
         FCD_B_HOLD: if (cnt_r == '0) begin
            st_nxt = FCD_B_IDLE;
            done_nxt = 1'b1;
         end else cnt_nxt = cnt_r - 1'b1;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r <= FCD_B_IDLE;
         cnt_r <= '0;
         cyc_r <= '0;
         rb_r <= '0;
         done_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         cyc_r <= cyc_nxt;
         rb_r <= rb_nxt;
         done_r <= done_nxt;
      end
   end

   // read: cs and oe low, we high; write: cs and we low, oe high
   assign busy = (st_r != FCD_B_IDLE);
   assign done = done_r;
   assign rd_byte = rb_r;
   assign cs_n = !busy;
   assign oe_n = !(st_r == FCD_B_STROBE && !cyc_r.write);
   assign we_n = !(st_r == FCD_B_STROBE && cyc_r.write);
   assign addr = cyc_r.addr;
   assign wdata = cyc_r.data;
   assign wdata_oe = busy && cyc_r.write;

   property p_strobe_excl;
      @(posedge core_clk) disable iff (rst) !(!oe_n && !we_n);
   endproperty
   a_strobe_excl: assert property (p_strobe_excl)
      else $error("read and write strobes both low");
endmodule : fcd_bus_cycle

// File: core/fcd_host.sv
// fcd_host: host controller issuing flash command sequences over pins
// assumes the flash data lines are joined from data_out/oe by the bench
`timescale 1ns/100ps
module fcd_host #(
   parameter int RST_PULSE_CYC = 13 // flash reset low time in cycles
) (
   input wire logic core_clk, // system clock
   input wire logic rst, // async reset, active high
   input wire logic req_valid, // request offered
   input wire fcd_pkg::fcd_req_t req, // operation, address, data
   output logic req_ready, // idle, request taken when valid
   output logic resp_valid, // one-cycle done pulse
   output logic [fcd_pkg::DATA_W-1:0] resp_data, // read or id byte
   output logic erase_active, // sector erase started, may suspend
   input wire logic [fcd_pkg::DATA_W-1:0] data_in, // flash data lines
   output fcd_pkg::fcd_pins_t pins // flash pin drives
);
   typedef enum logic [2:0] {FCD_IDLE, FCD_RSTPIN, FCD_ISSUE, FCD_WAIT,
      FCD_RESP} fcd_st_t;
   logic ready_r, ready_nxt;
   fcd_st_t st_r, st_nxt;
   fcd_pkg::fcd_req_t rq_r, rq_nxt;
   logic [2:0] idx_r, idx_nxt;
   logic [$clog2(RST_PULSE_CYC+1)-1:0] rc_r, rc_nxt;
   logic erase_r, erase_nxt;
   logic rv_r, rv_nxt;
   logic [fcd_pkg::DATA_W-1:0] rd_r, rd_nxt;
   logic idmode_r, idmode_nxt;
   logic [fcd_pkg::DATA_W-1:0] sync1_r, sync2_r;
   fcd_pkg::fcd_pins_t pins_r, pins_nxt;
   logic cy_start, cy_busy, cy_done;
   fcd_pkg::fcd_cyc_t cy;
   logic [fcd_pkg::DATA_W-1:0] cy_rbyte;
   logic b_cs, b_oe, b_we, b_doe;
   logic [fcd_pkg::ADDR_W-1:0] b_addr;
   logic [fcd_pkg::DATA_W-1:0] b_wd;
   logic [2:0] ncyc;

   // data lines come from another domain: two flops before use
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= data_in;
         sync2_r <= sync1_r;
      end
   end

   fcd_bus_cycle u_cyc (
      .core_clk(core_clk),
      .rst(rst),
      .start(cy_start),
      .cyc(cy),
      .rd_data(sync2_r),
      .busy(cy_busy),
      .done(cy_done),
      .rd_byte(cy_rbyte),
      .cs_n(b_cs),
      .oe_n(b_oe),
      .we_n(b_we),
      .addr(b_addr),
      .wdata(b_wd),
      .wdata_oe(b_doe)
   );

   // length of each sequence in bus cycles
   always_comb begin
      unique case (rq_r.op)
         fcd_pkg::FCD_OP_ID_READ, fcd_pkg::FCD_OP_PROT_VERIFY: ncyc =
            idmode_r ? 3'd1 : 3'd4;
         fcd_pkg::FCD_OP_PROGRAM: ncyc = 3'd4;
         fcd_pkg::FCD_OP_CHIP_ERASE,
         fcd_pkg::FCD_OP_SECTOR_ERASE: ncyc = 3'd6;
         default: ncyc = 3'd1;
      endcase
   end

   // cycle k of the current sequence
   always_comb begin
      cy.write = 1'b1;
      cy.addr = fcd_pkg::ADDR_UNLOCK1;
      cy.data = fcd_pkg::CMD_UNLOCK1;
      if (ncyc != 3'd1 && (idx_r == 3'd1 || idx_r == 3'd4)) begin
         cy.addr = fcd_pkg::ADDR_UNLOCK2;
         cy.data = fcd_pkg::CMD_UNLOCK2;
      end
      if (idx_r == ncyc - 3'd1) begin
         cy.addr = rq_r.addr;
         cy.data = rq_r.data;
         unique case (rq_r.op)
            fcd_pkg::FCD_OP_READ, fcd_pkg::FCD_OP_HV_ID_READ:
               cy.write = 1'b0;
            fcd_pkg::FCD_OP_ID_READ: begin
               cy.write = 1'b0;
               cy.addr = rq_r.addr[0] ? fcd_pkg::ID_DEVICE_LOC
                  : fcd_pkg::ID_MANUF_LOC;
            end
            fcd_pkg::FCD_OP_PROT_VERIFY: begin
               cy.write = 1'b0;
               cy.addr = fcd_pkg::ID_PROTECT_LOC;
               cy.addr[fcd_pkg::SECT_LSB +: fcd_pkg::SECT_W] =
                  rq_r.addr[fcd_pkg::SECT_LSB +: fcd_pkg::SECT_W];
            end
            fcd_pkg::FCD_OP_HV_PROTECT: begin
               cy.addr = fcd_pkg::ID_PROTECT_LOC;
               cy.addr[fcd_pkg::SECT_LSB +: fcd_pkg::SECT_W] =
                  rq_r.addr[fcd_pkg::SECT_LSB +: fcd_pkg::SECT_W];
               cy.addr[fcd_pkg::A6_BIT] = rq_r.unprotect;
            end
            fcd_pkg::FCD_OP_RESET: cy.data = fcd_pkg::CMD_RESET;
            fcd_pkg::FCD_OP_CHIP_ERASE:
               cy.data = fcd_pkg::CMD_CHIP_ERASE;
            fcd_pkg::FCD_OP_SECTOR_ERASE:
               cy.data = fcd_pkg::CMD_SECTOR_ERASE;
            fcd_pkg::FCD_OP_SUSPEND: cy.data = fcd_pkg::CMD_SUSPEND;
            fcd_pkg::FCD_OP_RESUME: cy.data = fcd_pkg::CMD_RESUME;
            default: ;
         endcase
      end else if (idx_r == 3'd2) begin
         unique case (rq_r.op)
            fcd_pkg::FCD_OP_PROGRAM: cy.data = fcd_pkg::CMD_PROGRAM;
            fcd_pkg::FCD_OP_CHIP_ERASE, fcd_pkg::FCD_OP_SECTOR_ERASE:
               cy.data = fcd_pkg::CMD_ERASE_SETUP;
            default: cy.data = fcd_pkg::CMD_AUTOSEL;
         endcase
      end
   end

   // sequence controller
   always_comb begin
      st_nxt = st_r;
      rq_nxt = rq_r;
      idx_nxt = idx_r;
      rc_nxt = rc_r;
      erase_nxt = erase_r;
      rv_nxt = 1'b0;
      rd_nxt = rd_r;
      idmode_nxt = idmode_r;
      cy_start = 1'b0;
      unique case (st_r)
         FCD_IDLE: if (req_valid) begin
            rq_nxt = req;
            idx_nxt = '0;
            // suspend/resume outside an erase would be refused
            if ((req.op == fcd_pkg::FCD_OP_SUSPEND ||
                 req.op == fcd_pkg::FCD_OP_RESUME) && !erase_r)
               st_nxt = FCD_RESP;
            else if (req.op == fcd_pkg::FCD_OP_RESET && req.unprotect) begin
               st_nxt = FCD_RSTPIN; // pin reset variant
               rc_nxt = '0;
            end else st_nxt = FCD_ISSUE;
         end
         FCD_RSTPIN: if (rc_r == ($bits(rc_r))'(RST_PULSE_CYC - 1)) begin
            st_nxt = FCD_RESP;
            erase_nxt = 1'b0;
            idmode_nxt = 1'b0;
         end else rc_nxt = rc_r + 1'b1;
         FCD_ISSUE: begin
            cy_start = 1'b1;
            st_nxt = FCD_WAIT;
         end
         FCD_WAIT: if (cy_done) begin
            if (idx_r == ncyc - 3'd1) begin
               rd_nxt = cy_rbyte;
               st_nxt = FCD_RESP;
               unique case (rq_r.op)
                  fcd_pkg::FCD_OP_ID_READ, fcd_pkg::FCD_OP_PROT_VERIFY:
                     idmode_nxt = 1'b1;
                  fcd_pkg::FCD_OP_RESET: begin
                     idmode_nxt = 1'b0;
                     erase_nxt = 1'b0;
                  end
                  fcd_pkg::FCD_OP_SECTOR_ERASE: erase_nxt = 1'b1;
                  fcd_pkg::FCD_OP_READ, fcd_pkg::FCD_OP_SUSPEND,
                  fcd_pkg::FCD_OP_RESUME, fcd_pkg::FCD_OP_HV_ID_READ: ;
                  default: idmode_nxt = 1'b0;
               endcase
            end else begin
               idx_nxt = idx_r + 3'd1;
               st_nxt = FCD_ISSUE;
            end
         end
         FCD_RESP: begin
            rv_nxt = 1'b1;
            st_nxt = FCD_IDLE;
         end
         default: st_nxt = FCD_IDLE;
      endcase
      // registered so the ready output comes straight from a flop
      ready_nxt = (st_nxt == FCD_IDLE);
   end

   // registered pin drives; high-voltage strobes only for their ops
   always_comb begin
      pins_nxt.chip_select_n = b_cs;
      pins_nxt.output_gate_n = b_oe;
      pins_nxt.write_strobe_n = b_we;
      pins_nxt.reset_n = (st_r != FCD_RSTPIN);
      pins_nxt.id_hv_a9 = cy_busy &&
         rq_r.op == fcd_pkg::FCD_OP_HV_ID_READ;
      pins_nxt.id_hv_reset = cy_busy &&
         rq_r.op == fcd_pkg::FCD_OP_HV_PROTECT;
      pins_nxt.addr = b_addr;
      pins_nxt.data_out = b_wd;
      pins_nxt.data_oe = b_doe;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r <= FCD_IDLE;
         rq_r <= '0;
         idx_r <= '0;
         rc_r <= '0;
         erase_r <= 1'b0;
         rv_r <= 1'b0;
         rd_r <= '0;
         idmode_r <= 1'b0;
         ready_r <= 1'b1;
         pins_r <= '{chip_select_n: 1'b1, output_gate_n: 1'b1,
            write_strobe_n: 1'b1, reset_n: 1'b1, default: '0};
      end else begin
         st_r <= st_nxt;
         rq_r <= rq_nxt;
         idx_r <= idx_nxt;
         rc_r <= rc_nxt;
         erase_r <= erase_nxt;
         rv_r <= rv_nxt;
         rd_r <= rd_nxt;
         idmode_r <= idmode_nxt;
         ready_r <= ready_nxt;
         pins_r <= pins_nxt;
      end
   end

   assign req_ready = ready_r;
   assign resp_valid = rv_r;
   assign resp_data = rd_r;
   assign erase_active = erase_r;
   assign pins = pins_r;

   property p_a9_read;
      @(posedge core_clk) disable iff (rst)
         pins.id_hv_a9 |-> pins.addr[fcd_pkg::A6_BIT] == 1'b0;
   endproperty
   a_a9_read: assert property (p_a9_read)
      else $error("a6 high during high-voltage id read");
   property p_wr_pins;
      @(posedge core_clk) disable iff (rst)
         !pins.write_strobe_n |-> !pins.chip_select_n &&
            pins.output_gate_n && pins.data_oe;
   endproperty
   a_wr_pins: assert property (p_wr_pins)
      else $error("write strobe without select or with gate");
   property p_rd_pins;
      @(posedge core_clk) disable iff (rst)
         !pins.output_gate_n |-> !pins.chip_select_n &&
            pins.write_strobe_n && !pins.data_oe;
   endproperty
   a_rd_pins: assert property (p_rd_pins)
      else $error("read gate without select or with strobe");
   property p_rst_len;
      @(posedge core_clk) disable iff (rst)
         $fell(pins.reset_n) |-> !pins.reset_n [*8];
   endproperty
   a_rst_len: assert property (p_rst_len)
      else $error("flash reset pulse too short");
   property p_susp_gate;
      @(posedge core_clk) disable iff (rst)
         (st_r == FCD_ISSUE && (rq_r.op == fcd_pkg::FCD_OP_SUSPEND ||
          rq_r.op == fcd_pkg::FCD_OP_RESUME)) |-> erase_r;
   endproperty
   a_susp_gate: assert property (p_susp_gate)
      else $error("suspend or resume issued outside erase");
   property p_resp_after;
      @(posedge core_clk) disable iff (rst)
         (st_r == FCD_WAIT && cy_done && idx_r == ncyc - 3'd1)
            |-> ##2 resp_valid;
   endproperty
   a_resp_after: assert property (p_resp_after)
      else $error("no response after final cycle");
endmodule : fcd_host

// File: bench/fcd_flash_model.sv
// fcd_flash_model: behavioural byte-wide flash with command decoder
// assumes the bench resolves the shared data lines into dq
`timescale 1ns/100ps
module fcd_flash_model #(
   parameter logic [7:0] MANUF_ID = 8'h5E, // arbitrary value
   parameter logic [7:0] DEV_ID = 8'h4B // arbitrary value
) (
   input wire logic cs_n, // chip select
   input wire logic oe_n, // output gate
   input wire logic we_n, // write strobe
   input wire logic reset_n, // hardware reset
   input wire logic hv_a9, // high voltage on address bit nine
   input wire logic hv_reset, // high voltage on reset pin
   input wire logic [19:0] addr, // address lines
   input wire logic [7:0] dq, // resolved data lines
   output logic [7:0] q, // read data
   output logic q_oe, // drives data lines
   output int n_wr, // completed write cycles
   output logic erasing // sector erase in progress
);
   logic [7:0] mem [logic [19:0]];
   logic [15:0] prot;
   logic id_mode;
   logic [19:0] lat_a;
   int st;

   function automatic logic [7:0] rd(input logic [19:0] a);
      return mem.exists(a) ? mem[a] : 8'hFF;
   endfunction : rd

   // one decoder step per completed write made without hv_reset; mismatch drops to read
   task automatic decode(input logic [19:0] a, input logic [7:0] d);
      logic [3:0] sec;
      sec = a[19:16];
      id_mode = 1'b0;
      case (st)
         0: begin
            if (d == 8'hF0) erasing = 1'b0;
            else if (erasing && (d == 8'hB0 || d == 8'h30)) st = 0;
            else if (d == 8'hAA && a == 20'h00AAA) st = 1;
         end
         1: st = (d == 8'h55 && a == 20'h00555) ? 2 : 0;
         2: begin
            st = 0;
            if (a == 20'h00AAA && d == 8'h90) id_mode = 1'b1;
            if (a == 20'h00AAA && d == 8'hA0) st = 3;
            if (a == 20'h00AAA && d == 8'h80) st = 4;
         end
         3: begin
            st = 0;
            if (!prot[sec]) mem[a] = rd(a) & d;
         end
         4: st = (d == 8'hAA && a == 20'h00AAA) ? 5 : 0;
         5: st = (d == 8'h55 && a == 20'h00555) ? 6 : 0;
         default: begin
            st = 0;
            if (d == 8'h10) mem.delete();
            if (d == 8'h30 && !prot[sec]) begin
               erasing = 1'b1;
               for (int i = 0; i < 65536; i++) mem[{sec, i[15:0]}] = 8'hFF;
            end
         end
      endcase
   endtask : decode

   // power-up: array read with one preset byte
   initial begin
      mem[20'h00040] = 8'h3C;
      prot = '0;
      st = 0;
      id_mode = 1'b0;
      erasing = 1'b0;
      n_wr = 0;
   end

   // hardware reset aborts everything and returns to array read
   always @(negedge reset_n) begin
      st = 0;
      id_mode = 1'b0;
      erasing = 1'b0;
   end

   // address at strobe fall, data at strobe rise
   always @(negedge we_n) if (!cs_n && reset_n) lat_a = addr;
   always @(posedge we_n) begin
      if (!cs_n && reset_n) begin
         n_wr++;
         if (hv_reset) begin
            if (lat_a[1:0] == 2'b10) prot[lat_a[19:16]] = !lat_a[6];
         end else begin
            decode(lat_a, dq);
         end
      end
   end

   // n_wr in the list so a rewrite of the read address is seen
   always @(addr or oe_n or cs_n or we_n or reset_n or id_mode or hv_a9
      or n_wr) begin
      q_oe = !cs_n && !oe_n && we_n && reset_n;
      if (id_mode || hv_a9) begin
         if (addr[1]) q = {7'h00, prot[addr[19:16]]};
         else q = addr[0] ? DEV_ID : MANUF_ID;
      end else begin
         q = rd(addr);
      end
   end
endmodule : fcd_flash_model

// File: bench/flash_command_decoder_test.sv
// flash_command_decoder_test: host controller against a flash model
// assumes fcd_pkg and fcd_host compiled before this file
`timescale 1ns/100ps
module flash_command_decoder_test;
   localparam logic [7:0] MANUF_ID = 8'h5E; // arbitrary value
   localparam logic [7:0] DEV_ID = 8'h4B; // arbitrary value
   logic core_clk, rst, req_valid, req_ready, resp_valid, erase_active;
   logic q_oe, erasing;
   logic [7:0] resp_data, dq, q, rd;
   logic [7:0] float_v = 8'h5A;
   fcd_pkg::fcd_req_t req;
   fcd_pkg::fcd_pins_t pins;
   int n_wr, w;
   int errors = 0;
   int n_checks = 0;

   fcd_host #(.RST_PULSE_CYC(8)) u_fcd_host (.core_clk(core_clk),
      .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .resp_valid(resp_valid), .resp_data(resp_data),
      .erase_active(erase_active), .data_in(dq), .pins(pins));
   fcd_flash_model #(.MANUF_ID(MANUF_ID), .DEV_ID(DEV_ID)) u_fcd_flash_model (
      .cs_n(pins.chip_select_n), .oe_n(pins.output_gate_n),
      .we_n(pins.write_strobe_n), .reset_n(pins.reset_n),
      .hv_a9(pins.id_hv_a9), .hv_reset(pins.id_hv_reset), .addr(pins.addr),
      .dq(dq), .q(q), .q_oe(q_oe), .n_wr(n_wr), .erasing(erasing));

   // undriven lines wander so a stale value never passes for data
   assign dq = pins.data_oe ? pins.data_out : (q_oe ? q : float_v);
   always @(posedge core_clk) float_v <= ~float_v;

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic finish_test();
      if (errors == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test

   // one request, offered for one cycle once ready, then wait for the done pulse
   task automatic run(input fcd_pkg::fcd_op_t op, input logic [19:0] a,
      input logic [7:0] d, input logic unp);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      req = '{op: op, addr: a, data: d, unprotect: unp};
      req_valid = 1'b1;
      @(posedge core_clk);
      #1;
      req_valid = 1'b0;
      n = 0;
      while (resp_valid !== 1'b1 && n < 300) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      check("response", {31'h0, resp_valid}, 32'h1);
      rd = resp_data;
   endtask : run

   // strobe combinations on every active cycle
   always @(posedge core_clk) begin
      if (!pins.output_gate_n) check("read pins",
         {pins.chip_select_n, pins.write_strobe_n}, 2'b01);
      if (!pins.write_strobe_n) check("write pins", {pins.chip_select_n,
         pins.output_gate_n, pins.data_oe}, 3'b011);
   end

   task automatic t_read_array();
      run(fcd_pkg::FCD_OP_READ, 20'h00040, 8'h00, 1'b0);
      check("array byte", rd, 8'h3C);
      run(fcd_pkg::FCD_OP_READ, 20'h00040, 8'h00, 1'b0);
      check("array again", rd, 8'h3C);
      check("no writes", n_wr, 0);
   endtask : t_read_array

   task automatic t_program();
      w = n_wr;
      run(fcd_pkg::FCD_OP_PROGRAM, 20'h23456, 8'hA5, 1'b0);
      check("program writes", n_wr - w, 4);
      run(fcd_pkg::FCD_OP_READ, 20'h23456, 8'h00, 1'b0);
      check("program read", rd, 8'hA5);
   endtask : t_program

   task automatic t_ident();
      run(fcd_pkg::FCD_OP_ID_READ, 20'h00000, 8'h00, 1'b0);
      check("manuf code", rd, MANUF_ID);
      w = n_wr;
      run(fcd_pkg::FCD_OP_ID_READ, 20'hABCD1, 8'h00, 1'b0);
      check("device code", rd, DEV_ID);
      check("id held writes", n_wr - w, 0);
      run(fcd_pkg::FCD_OP_READ, 20'h00040, 8'h00, 1'b0);
      check("id mode read", rd, MANUF_ID);
      run(fcd_pkg::FCD_OP_RESET, 20'h12345, 8'h00, 1'b0);
      run(fcd_pkg::FCD_OP_READ, 20'h00040, 8'h00, 1'b0);
      check("after reset cmd", rd, 8'h3C);
   endtask : t_ident

   task automatic t_pin_reset();
      run(fcd_pkg::FCD_OP_ID_READ, 20'h00001, 8'h00, 1'b0);
      check("id before pulse", rd, DEV_ID);
      w = n_wr;
      run(fcd_pkg::FCD_OP_RESET, 20'h00000, 8'h00, 1'b1);
      check("pulse writes", n_wr - w, 0);
      run(fcd_pkg::FCD_OP_READ, 20'h00040, 8'h00, 1'b0);
      check("after pin reset", rd, 8'h3C);
   endtask : t_pin_reset

   task automatic t_protect();
      run(fcd_pkg::FCD_OP_HV_PROTECT, 20'h30000, 8'h00, 1'b0);
      run(fcd_pkg::FCD_OP_PROT_VERIFY, 20'h30002, 8'h00, 1'b0);
      check("protected", rd, 8'h01);
      run(fcd_pkg::FCD_OP_PROT_VERIFY, 20'h40002, 8'h00, 1'b0);
      check("unprotected", rd, 8'h00);
      run(fcd_pkg::FCD_OP_HV_PROTECT, 20'h30000, 8'h00, 1'b1);
      run(fcd_pkg::FCD_OP_PROT_VERIFY, 20'h30002, 8'h00, 1'b0);
      check("unprotect", rd, 8'h00);
      run(fcd_pkg::FCD_OP_RESET, 20'h00000, 8'h00, 1'b0);
      run(fcd_pkg::FCD_OP_HV_ID_READ, 20'h00001, 8'h00, 1'b0);
      check("hv device code", rd, DEV_ID);
   endtask : t_protect

   task automatic t_erase();
      w = n_wr;
      run(fcd_pkg::FCD_OP_SUSPEND, 20'h00000, 8'h00, 1'b0);
      check("idle suspend", n_wr - w, 0);
      run(fcd_pkg::FCD_OP_CHIP_ERASE, 20'h00000, 8'h00, 1'b0);
      check("chip erase writes", n_wr - w, 6);
      run(fcd_pkg::FCD_OP_READ, 20'h23456, 8'h00, 1'b0);
      check("chip erased", rd, 8'hFF);
      run(fcd_pkg::FCD_OP_PROGRAM, 20'h50010, 8'h77, 1'b0);
      run(fcd_pkg::FCD_OP_SECTOR_ERASE, 20'h50000, 8'h00, 1'b0);
      check("erase flag", {erase_active, erasing}, 2'b11);
      run(fcd_pkg::FCD_OP_READ, 20'h50010, 8'h00, 1'b0);
      check("sector erased", rd, 8'hFF);
      w = n_wr;
      run(fcd_pkg::FCD_OP_SUSPEND, 20'h00000, 8'h00, 1'b0);
      run(fcd_pkg::FCD_OP_RESUME, 20'h00000, 8'h00, 1'b0);
      check("suspend resume", n_wr - w, 2);
      run(fcd_pkg::FCD_OP_RESET, 20'h00000, 8'h00, 1'b0);
      check("erase cleared", erase_active, 1'b0);
   endtask : t_erase

   // watchdog of 20000 cycles, well beyond the few hundred cycles the tests need
   initial begin
      #(40 * 20000);
      errors++;
      finish_test();
   end

   // reset, then the scenarios in turn
   initial begin
      rst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      repeat (20) @(posedge core_clk);
      #1;
      rst = 1'b0;
      t_read_array();
      t_program();
      t_ident();
      t_pin_reset();
      t_protect();
      t_erase();
      finish_test();
   end
endmodule : flash_command_decoder_test
